/* rtl/rss_pkg.sv */
/*
 * Constants for the rotate, subtract and sleep execution block: register map,
 * field positions, reset values, operation codes and controller states.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses in 8 bits.
 */
// Functional notes
// RQ1 - Rotate left moves file register 0 to 127 up one bit through carry as a ninth bit, changing only carry.
// RQ2 - For a rotate, destination 0 puts the result in the accumulator only, 1 writes it back to the file register.
// RQ3 - Rotate right moves the file register down one bit through carry as a ninth bit, changing only carry.
// RQ4 - Sleep clears the power-down flag and sets the time-out flag and touches no other flag.
// RQ5 - Sleep clears the watchdog counter and its prescaler.
// RQ6 - After sleep, execution halts and the oscillator is stopped until wake-up; the code only refuses new commands, the clock keeps running.
// RQ7 - Literal-minus-accumulator puts literal minus accumulator, 8 bits in two's complement, into the accumulator.
// RQ8 - The subtract updates carry, half-carry and zero; carry is 0 when the accumulator exceeds the literal, else 1.
`default_nettype none
package rss_pkg;
    typedef logic [7:0]  rss_addr_t;
    typedef logic [31:0] rss_word_t;
    typedef logic [7:0]  rss_byte_t;
    typedef logic [6:0]  rss_faddr_t;

    // Operation codes held in the command register
    typedef enum logic [1:0]
    {
        OP_ROT_LEFT  = 2'h0,
        OP_ROT_RIGHT = 2'h1,
        OP_LIT_SUB   = 2'h2,
        OP_SLEEP     = 2'h3
    } rss_op_t;

    // Controller states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_OP_FETCH,
        ST_OP_EXEC,
        ST_WR_RESP,
        ST_RD_WAIT,
        ST_RD_RESP
    } rss_state_t;

    // Register byte offsets
    localparam rss_addr_t REG_CMD    = 8'h00;
    localparam rss_addr_t REG_ACC    = 8'h04;
    localparam rss_addr_t REG_STATUS = 8'h08;
    localparam rss_addr_t REG_FADDR  = 8'h0c;
    localparam rss_addr_t REG_FDATA  = 8'h10;
    localparam rss_addr_t REG_SLEEP  = 8'h14;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_DEST_BIT = 2;
    localparam int CMD_FA_LSB   = 8;
    localparam int CMD_LIT_LSB  = 16;

    // Status register bit positions
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_HALF_BIT  = 1;
    localparam int ST_ZERO_BIT  = 2;
    localparam int ST_TOUT_BIT  = 3;
    localparam int ST_PDOWN_BIT = 4;

    // Sleep register bit position
    localparam int SLP_ACTIVE_BIT = 0;

    // Reset values
    localparam rss_byte_t  ACC_RST      = 8'h00;
    localparam logic       CARRY_RST    = 1'b0;
    localparam logic       HALF_RST     = 1'b0;
    localparam logic       ZERO_RST     = 1'b0;
    localparam logic       TIMEOUT_RST  = 1'b1;
    localparam logic       PDOWN_RST    = 1'b1;
    localparam rss_faddr_t FADDR_RST    = 7'h00;
    localparam rss_word_t  CMD_RST      = 32'h0000_0000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* rtl/rss_if.sv */
/*
 * Carriers between the controller, its file memory and its arithmetic unit.
 * Assumes all parties sit on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface rss_ram_if;
    logic [6:0] addr;
    logic       wr_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output addr, output wr_en, output wdata, input rdata);
    modport mem  (input addr, input wr_en, input wdata, output rdata);
endinterface

interface rss_alu_if;
    logic [1:0] op;
    logic [7:0] fval;
    logic [7:0] acc;
    logic [7:0] lit;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       half_out;
    logic       zero_out;
    modport core (output op, output fval, output acc, output lit, output carry_in,
                  input result, input carry_out, input half_out, input zero_out);
    modport unit (input op, input fval, input acc, input lit, input carry_in,
                  output result, output carry_out, output half_out, output zero_out);
endinterface
`default_nettype wire

/* rtl/rss_file_ram.sv */
/*
 * File register memory, 128 bytes, one write and one registered read port.
 * Assumes a single clock; read data appear one edge after the address.
 */
`timescale 1ns/100ps
`default_nettype none
module rss_file_ram #(
    parameter int DEPTH = 128
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    rss_ram_if.mem    ram
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rd_q;

    // Write port and registered read
    always_ff @(posedge aclk)
    begin
        if (ram.wr_en)
        begin
            mem[ram.addr] <= ram.wdata;
        end
        if (!aresetn)
        begin
            rd_q <= 8'h00;
        end
        else
        begin
            rd_q <= mem[ram.addr];
        end
    end

    assign ram.rdata = rd_q;
endmodule
`default_nettype wire

/* rtl/rss_alu.sv */
/*
 * Combinational arithmetic for rotate through carry and literal minus accumulator.
 * Assumes the caller selects which results to keep.
 */
`timescale 1ns/100ps
`default_nettype none
module rss_alu (
    rss_alu_if.unit alu
);
    import rss_pkg::*;

    logic [8:0] diff;
    logic [4:0] nib;

    // Two's complement difference with carry as inverted borrow
    assign diff = {1'b0, alu.lit} + {1'b0, ~alu.acc} + 9'h001;        // see RQ7
    assign nib  = {1'b0, alu.lit[3:0]} + {1'b0, ~alu.acc[3:0]} + 5'h01;

    // Result and flag selection per operation
    always_comb
    begin
        alu.result    = 8'h00;
        alu.carry_out = alu.carry_in;
        alu.half_out  = nib[4];
        alu.zero_out  = 1'b0;
        unique case (alu.op)
            OP_ROT_LEFT:
            begin
                {alu.carry_out, alu.result} = {alu.fval, alu.carry_in};   // see RQ1
            end
            OP_ROT_RIGHT:
            begin
                {alu.result, alu.carry_out} = {alu.carry_in, alu.fval};   // see RQ3
            end
            OP_LIT_SUB:
            begin
                alu.result    = diff[7:0];                                // see RQ7
                alu.carry_out = diff[8];                                  // see RQ8
                alu.zero_out  = (diff[7:0] == 8'h00);                     // see RQ8
            end
            OP_SLEEP:
            begin
                alu.result = alu.acc;
            end
        endcase
    end
endmodule
`default_nettype wire

/* rtl/rss_top.sv */
/*
 * Execution block for rotate through carry, literal minus accumulator and sleep,
 * reached over AXI4-Lite. Writing the command register runs one operation unless the core is
 * halted; the write answer comes when it has finished.
 * Assumes the watchdog honours watchdog_clear and that wake_pin is asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module rss_top (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire rss_pkg::rss_addr_t s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire rss_pkg::rss_word_t s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire rss_pkg::rss_addr_t s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output rss_pkg::rss_word_t     s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              wake_pin,
    output logic                   sleep_active,
    output logic                   watchdog_clear
);
    import rss_pkg::*;

    rss_ram_if ram ();
    rss_alu_if alu ();

    rss_state_t state, next_state;
    rss_addr_t  aw_addr, next_aw_addr;
    logic       aw_held, next_aw_held;
    rss_word_t  w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic       w_held, next_w_held;
    rss_addr_t  ar_addr, next_ar_addr;
    logic [1:0] bresp, next_bresp;
    rss_word_t  rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    rss_word_t  cmd, next_cmd;
    rss_byte_t  acc, next_acc;
    logic       carry, next_carry;
    logic       half_carry_flag, next_half_carry_flag;
    logic       zero, next_zero;
    logic       timeout_flag, next_timeout_flag;
    logic       powerdown_flag, next_powerdown_flag;
    rss_faddr_t faddr, next_faddr;
    logic       sleeping, next_sleeping;
    logic       wdog_clr, next_wdog_clr;
    logic       wake_meta, wake_sync;

    rss_op_t    cmd_op;
    logic       cmd_dest;
    rss_faddr_t cmd_fa;
    rss_byte_t  cmd_lit;
    rss_word_t  wr_merged, rd_word, cur_word;
    logic       wr_mapped, rd_mapped;

    // Memory and arithmetic units
    rss_file_ram #(
        .DEPTH (128)
    ) u_ram (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ram     (ram)
    );

    rss_alu u_alu (
        .alu (alu)
    );

    // Command fields
    assign cmd_op   = rss_op_t'(cmd[CMD_OP_LSB +: 2]);
    assign cmd_dest = cmd[CMD_DEST_BIT];
    assign cmd_fa   = cmd[CMD_FA_LSB +: 7];
    assign cmd_lit  = cmd[CMD_LIT_LSB +: 8];

    // Operands for the arithmetic unit
    assign alu.op       = cmd_op;
    assign alu.fval     = ram.rdata;
    assign alu.acc      = acc;
    assign alu.lit      = cmd_lit;
    assign alu.carry_in = carry;

    // Bus handshakes
    assign s_axi_awready = (state == ST_IDLE) && !aw_held;
    assign s_axi_wready  = (state == ST_IDLE) && !w_held;
    assign s_axi_arready = (state == ST_IDLE) && !aw_held && !w_held;
    assign s_axi_bvalid  = (state == ST_WR_RESP);
    assign s_axi_rvalid  = (state == ST_RD_RESP);
    assign s_axi_bresp   = bresp;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;
    assign sleep_active  = sleeping;
    assign watchdog_clear = wdog_clr;

    // Current value of the addressed write target, for byte merging
    always_comb
    begin
        cur_word  = 32'h0000_0000;
        wr_mapped = 1'b1;
        unique case (aw_addr)
            REG_CMD:    cur_word = cmd;
            REG_ACC:    cur_word = {24'h00_0000, acc};
            REG_STATUS: cur_word = {27'h000_0000, powerdown_flag, timeout_flag, zero, half_carry_flag, carry};
            REG_FADDR:  cur_word = {25'h000_0000, faddr};
            REG_FDATA:  cur_word = 32'h0000_0000;
            REG_SLEEP:  cur_word = 32'h0000_0000;
            default:    wr_mapped = 1'b0;
        endcase
        for (int i = 0; i < 4; i++)
            wr_merged[8*i +: 8] = w_strb[i] ? w_data[8*i +: 8] : cur_word[8*i +: 8];
    end

    // Read data multiplexer
    always_comb
    begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b1;
        unique case (ar_addr)
            REG_CMD:    rd_word = cmd;
            REG_ACC:    rd_word = {24'h00_0000, acc};
            REG_STATUS: rd_word = {27'h000_0000, powerdown_flag, timeout_flag, zero, half_carry_flag, carry};
            REG_FADDR:  rd_word = {25'h000_0000, faddr};
            REG_FDATA:  rd_word = {24'h00_0000, ram.rdata};
            REG_SLEEP:  rd_word = {31'h0000_0000, sleeping};
            default:    rd_mapped = 1'b0;
        endcase
    end

    // Memory port: fetch and write-back during operations, else bus access
    always_comb
    begin
        ram.addr  = faddr;
        ram.wr_en = 1'b0;
        ram.wdata = w_data[7:0];
        if (state == ST_OP_FETCH || state == ST_OP_EXEC)
        begin
            ram.addr  = cmd_fa;                                           // see RQ1
            ram.wdata = alu.result;
            ram.wr_en = (state == ST_OP_EXEC) && cmd_dest &&
                        (cmd_op == OP_ROT_LEFT || cmd_op == OP_ROT_RIGHT);   // see RQ2
        end
        else if (state == ST_IDLE && aw_held && w_held && aw_addr == REG_FDATA)
            ram.wr_en = w_strb[0];
    end

    // Controller next state, register file and operation execution
    always_comb
    begin
        next_state           = state;
        next_aw_addr         = aw_addr;
        next_aw_held         = aw_held;
        next_w_data          = w_data;
        next_w_strb          = w_strb;
        next_w_held          = w_held;
        next_ar_addr         = ar_addr;
        next_bresp           = bresp;
        next_rdata           = rdata;
        next_rresp           = rresp;
        next_cmd             = cmd;
        next_acc             = acc;
        next_carry           = carry;
        next_half_carry_flag = half_carry_flag;
        next_zero            = zero;
        next_timeout_flag    = timeout_flag;
        next_powerdown_flag  = powerdown_flag;
        next_faddr           = faddr;
        next_sleeping        = sleeping;
        next_wdog_clr        = 1'b0;
        // Wake-up ends the halted state
        if (wake_sync)
            next_sleeping = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                if (s_axi_awvalid && !aw_held)
                begin
                    next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
                    next_aw_held = 1'b1;
                end
                if (s_axi_wvalid && !w_held)
                begin
                    next_w_data = s_axi_wdata;
                    next_w_strb = s_axi_wstrb;
                    next_w_held = 1'b1;
                end
                if (aw_held && w_held)
                begin
                    next_aw_held = 1'b0;
                    next_w_held  = 1'b0;
                    next_bresp   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
                    next_state   = ST_WR_RESP;
                    unique case (aw_addr)
                        REG_CMD:
                        begin
                            next_cmd = wr_merged;
                            // Halted core refuses new operations
                            if (!sleeping)
                                next_state = ST_OP_FETCH;
                        end
                        REG_ACC:    next_acc = wr_merged[7:0];
                        REG_STATUS:
                        begin
                            next_carry           = wr_merged[ST_CARRY_BIT];
                            next_half_carry_flag = wr_merged[ST_HALF_BIT];
                            next_zero            = wr_merged[ST_ZERO_BIT];
                            next_timeout_flag    = wr_merged[ST_TOUT_BIT];
                            next_powerdown_flag  = wr_merged[ST_PDOWN_BIT];
                        end
                        REG_FADDR:  next_faddr = wr_merged[6:0];
                        REG_SLEEP:
                        begin
                            if (w_strb[0] && w_data[SLP_ACTIVE_BIT])
                                next_sleeping = 1'b0;
                        end
                        default:    next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
                    endcase
                end
                else if (s_axi_arvalid && !aw_held && !w_held)
                begin
                    next_ar_addr = {s_axi_araddr[7:2], 2'b00};
                    next_state   = ST_RD_WAIT;
                end
            end
            ST_OP_FETCH:
                next_state = ST_OP_EXEC;
            ST_OP_EXEC:
            begin
                next_state = ST_WR_RESP;
                unique case (cmd_op)
                    OP_ROT_LEFT, OP_ROT_RIGHT:
                    begin
                        next_carry = alu.carry_out;                       // see RQ1 see RQ3
                        if (!cmd_dest)
                            next_acc = alu.result;                        // see RQ2
                    end
                    OP_LIT_SUB:
                    begin
                        next_acc             = alu.result;                // see RQ7
                        next_carry           = alu.carry_out;             // see RQ8
                        next_half_carry_flag = alu.half_out;              // see RQ8
                        next_zero            = alu.zero_out;              // see RQ8
                    end
                    OP_SLEEP:
                    begin
                        next_powerdown_flag = 1'b0;                       // see RQ4
                        next_timeout_flag   = 1'b1;                       // see RQ4
                        next_wdog_clr       = 1'b1;                       // see RQ5
                        next_sleeping       = 1'b1;                       // see RQ6
                    end
                endcase
            end
            ST_WR_RESP:
                if (s_axi_bready)
                    next_state = ST_IDLE;
            ST_RD_WAIT:
            begin
                next_rdata = rd_mapped ? rd_word : 32'h0000_0000;
                next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
                next_state = ST_RD_RESP;
            end
            ST_RD_RESP:
                if (s_axi_rready)
                    next_state = ST_IDLE;
        endcase
    end

    // State registers with synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state           <= ST_IDLE;
            aw_addr         <= 8'h00;
            aw_held         <= 1'b0;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            w_held          <= 1'b0;
            ar_addr         <= 8'h00;
            bresp           <= RESP_OKAY;
            rdata           <= 32'h0000_0000;
            rresp           <= RESP_OKAY;
            cmd             <= CMD_RST;
            acc             <= ACC_RST;
            carry           <= CARRY_RST;
            half_carry_flag <= HALF_RST;
            zero            <= ZERO_RST;
            timeout_flag    <= TIMEOUT_RST;
            powerdown_flag  <= PDOWN_RST;
            faddr           <= FADDR_RST;
            sleeping        <= 1'b0;
            wdog_clr        <= 1'b0;
            wake_meta       <= 1'b0;
            wake_sync       <= 1'b0;
        end
        else
        begin
            state           <= next_state;
            aw_addr         <= next_aw_addr;
            aw_held         <= next_aw_held;
            w_data          <= next_w_data;
            w_strb          <= next_w_strb;
            w_held          <= next_w_held;
            ar_addr         <= next_ar_addr;
            bresp           <= next_bresp;
            rdata           <= next_rdata;
            rresp           <= next_rresp;
            cmd             <= next_cmd;
            acc             <= next_acc;
            carry           <= next_carry;
            half_carry_flag <= next_half_carry_flag;
            zero            <= next_zero;
            timeout_flag    <= next_timeout_flag;
            powerdown_flag  <= next_powerdown_flag;
            faddr           <= next_faddr;
            sleeping        <= next_sleeping;
            wdog_clr        <= next_wdog_clr;
            wake_meta       <= wake_pin;   // Synchroniser first stage
            wake_sync       <= wake_meta;
        end
    end
endmodule
`default_nettype wire

/* dv/rss_monitor.sv */
/* Port timing checks for rss_top.
   Bound to rss_top by the bench; one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module rss_monitor (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire rss_pkg::rss_word_t s_axi_rdata,
    input wire logic               wake_pin,
    input wire logic               sleep_active,
    input wire logic               watchdog_clear
);
    import rss_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Sleep side effects
    a_clear_pulse: assert property (watchdog_clear |=> !watchdog_clear)
        else $error("watchdog clear longer than one cycle");
    a_clear_sleeps: assert property (watchdog_clear |-> ##[0:1] sleep_active)
        else $error("no halt after watchdog clear");
    a_sleep_cause: assert property ($rose(sleep_active) |-> watchdog_clear || $past(watchdog_clear))
        else $error("halt without watchdog clear");
    a_clear_resp: assert property (watchdog_clear |-> $rose(s_axi_bvalid))
        else $error("watchdog clear not tied to command answer");
    a_wake_ends: assert property (sleep_active && wake_pin |-> ##[1:4] !sleep_active)
        else $error("wake request ignored");
    // Bus timing
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_busy_block: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_arready)
        else $error("request accepted while busy");
    a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
        && !watchdog_clear && !sleep_active) else $error("outputs not idle in reset");
endmodule
`default_nettype wire

/* dv/rss_wdog_model.sv */
/* Watchdog and wake source facing the block.
   Same clock and reset as rss_top. */
`timescale 1ns/100ps
`default_nettype none
module rss_wdog_model (
    input wire logic  aclk,
    input wire logic  aresetn,
    input wire logic  watchdog_clear,
    input wire logic  sleep_active,
    input wire logic  wake_req,
    output logic      wake_pin,
    output logic [7:0] clr_cnt
);
    // Counts the clears seen, one per sleep
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clr_cnt <= 8'h00;
        else if (watchdog_clear)
            clr_cnt <= clr_cnt + 8'h01;
    end
    // Wake held only while halted and asked for
    assign wake_pin = wake_req && sleep_active;
endmodule
`default_nettype wire

/* dv/tb.sv */
/* Self-checking bench for rss_top over AXI4-Lite.
   Needs rss_monitor and rss_wdog_model. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rss_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, wake_req = 1'b0, wake_pin, sleep_active, watchdog_clear;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    rss_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    rss_word_t s_axi_wdata = 32'h0, s_axi_rdata, rd_data, c;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
    logic [7:0] clr_cnt;
    int error_cnt = 0, n_compared = 0;
    // cmd, acc, file, status, then expected acc, file, status
    logic [79:0] rows [8] = '{80'h00000504_118118_110219, 80'h00007f00_114019_814018,
        80'h00000005_11011f_11801f, 80'h00000301_110218_010218, 80'h00050002_050018_00001f,
        80'h00000002_01001f_ff0018, 80'h00ff0002_000018_ff001b, 80'h00100002_01001e_0f0019};
    rss_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_pin, .sleep_active, .watchdog_clear);
    rss_wdog_model wd (.aclk, .aresetn, .watchdog_clear, .sleep_active, .wake_req, .wake_pin, .clr_cnt);
    always #25 aclk = ~aclk;
    task automatic chk(input rss_word_t s, input rss_word_t e);
        n_compared++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input rss_addr_t a, input rss_word_t d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Read: ready raised late so the answer must stand
    task automatic rd(input rss_addr_t a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input rss_addr_t a, input rss_word_t e);
        rd(a);
        chk(rd_data, e);
    endtask
    task end_sim;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc(REG_ACC, 32'h0);
        rc(REG_STATUS, 32'h18);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            c = rows[i][79:48];
            wr(REG_ACC, {24'h0, rows[i][47:40]});
            wr(REG_STATUS, {24'h0, rows[i][31:24]});
            wr(REG_FADDR, {25'h0, c[14:8]});
            wr(REG_FDATA, {24'h0, rows[i][39:32]});
            wr(REG_CMD, c);
            rc(REG_ACC, {24'h0, rows[i][23:16]});
            rc(REG_FDATA, {24'h0, rows[i][15:8]});
            rc(REG_STATUS, {24'h0, rows[i][7:0]});
            $display("row %0d done", i);
        end
        wr(REG_ACC, 32'h3c);
        wr(REG_STATUS, 32'h07);
        wr(REG_CMD, 32'h3);
        chk({31'h0, sleep_active}, 32'h1);
        rc(REG_STATUS, 32'h0f);
        chk({24'h0, clr_cnt}, 32'h1);
        wr(REG_CMD, 32'h0);
        rc(REG_ACC, 32'h3c);
        wake_req <= 1'b1;
        repeat (8) @(posedge aclk);
        wake_req <= 1'b0;
        chk({31'h0, sleep_active}, 32'h0);
        wr(REG_CMD, 32'h3);
        rc(REG_SLEEP, 32'h1);
        wr(REG_SLEEP, 32'h1);
        rc(REG_SLEEP, 32'h0);
        chk({24'h0, clr_cnt}, 32'h2);
        $display("sleep test done");
        rc(8'h18, 32'h0);
        chk({30'h0, rd_resp}, 32'h2);
        wr(8'h1c, 32'h1);
        chk({30'h0, wr_resp}, 32'h2);
        $display("unmapped test done");
        end_sim();
    end
    // Watchdog on the whole run
    initial
    begin
        #150000;
        error_cnt++;
        end_sim();
    end
endmodule
bind rss_top rss_monitor mon (.aclk, .aresetn, .s_axi_awready, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .wake_pin, .sleep_active, .watchdog_clear);
`default_nettype wire
